// ===== dpdc_regs.vh
// constants for the dual prescaled down counter: offsets, fields, reset values, timing
// Notes on behaviour
// - two independent 8-bit counters, each with its own 6-bit prescaler
// - timer zero prescaler takes internal clock only; timer one may take external
// - each prescaler divides its input by a programmed ratio from 1 to 64
// - counter decrements per prescaler pulse from a loaded count of 1 to 256
// - end of count raises a separate request for each timer
// - counters can be started, stopped, resumed and restarted from initial value
// - single-pass mode halts at zero until restarted
// - continuous mode reloads initial value at end of count and keeps counting
// - reading counts disturbs nothing; prescaler contents are not readable
// - timer one source is internal clock divided by four or external pin
// - external input acts as clock, retrigger, one-shot trigger or gate; ext clock max 1 MHz
// - cascade routes timer zero output into timer one input
// - port3 line six outputs timer zero, timer one or the internal clock
`ifndef DPDC_REGS_VH
`define DPDC_REGS_VH

// register word index (byte address = index * 4)
`define DPDC_IDX_CTRL        4'h0
`define DPDC_IDX_RELOAD_A    4'h1
`define DPDC_IDX_RELOAD_B    4'h2
`define DPDC_IDX_SCALE_A     4'h3
`define DPDC_IDX_SCALE_B     4'h4
`define DPDC_IDX_COUNT_A     4'h5
`define DPDC_IDX_COUNT_B     4'h6
`define DPDC_IDX_MODE        4'h7
`define DPDC_IDX_STATUS      4'h8
`define DPDC_IDX_MASK        4'h9

// control register fields
`define DPDC_CTRL_RUN_A      0
`define DPDC_CTRL_RESTART_A  1
`define DPDC_CTRL_CONT_A     2
`define DPDC_CTRL_ACTIVE_A   3
`define DPDC_CTRL_RUN_B      4
`define DPDC_CTRL_RESTART_B  5
`define DPDC_CTRL_CONT_B     6
`define DPDC_CTRL_ACTIVE_B   7

// mode register fields
`define DPDC_MODE_SRC_LO     0
`define DPDC_MODE_SRC_HI     1
`define DPDC_MODE_RETRIG     2
`define DPDC_MODE_CASCADE    3
`define DPDC_MODE_OSEL_LO    4
`define DPDC_MODE_OSEL_HI    5
`define DPDC_MODE_OUT_EN     6

// timer one input modes
`define DPDC_SRC_INTERNAL    2'h0
`define DPDC_SRC_EXT_CLOCK   2'h1
`define DPDC_SRC_TRIGGER     2'h2
`define DPDC_SRC_GATE        2'h3

// output pin selections
`define DPDC_OSEL_TIMER_A    2'h0
`define DPDC_OSEL_TIMER_B    2'h1
`define DPDC_OSEL_INT_CLOCK  2'h2

// reset values
`define DPDC_RST_RELOAD      8'h00
`define DPDC_RST_SCALE       6'h00
`define DPDC_RST_MODE        7'h00
`define DPDC_RST_MASK        2'h0

// internal clock divider ahead of the prescalers
`define DPDC_INT_DIV         4
`define DPDC_INT_DIV_W       2
`define DPDC_INT_DIV_LAST    2'h3

// fastest external clock, in kHz
`define DPDC_EXT_CLK_MAX_KHZ 1000

`endif

// ===== dpdc_chan.v
// one counter channel: 6-bit prescaler feeding an 8-bit down counter
`timescale 1ns/100ps
module dpdc_chan #(
  parameter CW = 8,
  parameter PW = 6
) (
  // clock and reset
  input  wire          clock_in,
  input  wire          rst_n_in,
  // control
  input  wire          tick_in,
  input  wire          run_in,
  input  wire          load_in,
  input  wire          cont_in,
  input  wire [PW-1:0] scale_in,
  input  wire [CW-1:0] reload_in,
  // state
  output wire [CW-1:0] count_out,
  output wire          done_out,
  output wire          active_out
);

  reg [PW-1:0] pre_reg;
  reg [CW-1:0] cnt_reg;
  reg          act_reg;
  reg          done_reg;

  // a scale or reload of zero means the full range (64, 256)
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      pre_reg  <= {PW{1'b0}};
      cnt_reg  <= {CW{1'b0}};
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (load_in) begin
        cnt_reg <= reload_in;
        pre_reg <= scale_in - {{(PW-1){1'b0}}, 1'b1};
        act_reg <= 1'b1;
      end else if (act_reg && run_in && tick_in) begin
        if (pre_reg == {PW{1'b0}}) begin
          pre_reg <= scale_in - {{(PW-1){1'b0}}, 1'b1};
          if (cnt_reg == {{(CW-1){1'b0}}, 1'b1}) begin
            done_reg <= 1'b1;
            if (cont_in) begin
              cnt_reg <= reload_in;
            end else begin
              cnt_reg <= {CW{1'b0}};
              act_reg <= 1'b0;
            end
          end else begin
            cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
          end
        end else begin
          pre_reg <= pre_reg - {{(PW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign count_out  = cnt_reg;
  assign done_out   = done_reg;
  assign active_out = act_reg;

endmodule // dpdc_chan

// ===== dpdc_timer.v
// dual prescaled down counter top: avalon slave, two channels, input modes, output pin, interrupts
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "dpdc_regs.vh"
module dpdc_timer #(
  parameter CW = 8,
  parameter PW = 6
) (
  // clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // avalon-mm slave
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // external timer input pin
  input  wire        timer_in_pin_in,
  // port3 line six timer output
  output wire        port3_line6_out,
  output wire        port3_line6_oe_out,
  // interrupts
  output wire        count_done_req_a_out,
  output wire        count_done_req_b_out,
  output wire        irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg           wait_reg;
  reg  [31:0]   rdata_reg;
  reg           run_a_reg;
  reg           cont_a_reg;
  reg           run_b_reg;
  reg           cont_b_reg;
  reg           restart_a_reg;
  reg           restart_b_reg;
  reg  [CW-1:0] reload_a_reg;
  reg  [CW-1:0] reload_b_reg;
  reg  [PW-1:0] scale_a_reg;
  reg  [PW-1:0] scale_b_reg;
  reg  [6:0]    mode_reg;
  reg  [1:0]    status_reg;
  reg  [1:0]    mask_reg;
  reg           irq_reg;
  reg  [`DPDC_INT_DIV_W-1:0] div_reg;
  reg           pin_meta_reg;
  reg           pin_sync_reg;
  reg           pin_prev_reg;
  reg           tog_a_reg;
  reg           tog_b_reg;
  reg           tog_clk_reg;
  reg           timer_out_pin_reg;
  reg           timer_out_pin_oe_reg;
  reg           tick_b_next;
  reg  [31:0]   rdata_next;
  reg  [1:0]    status_next;
  reg           timer_out_pin_next;

  wire          acc_go;
  wire          acc_wr;
  wire [3:0]    acc_idx;
  wire          tick_int;
  wire          ext_edge;
  wire [1:0]    src_mode;
  wire [1:0]    out_sel;
  wire          retrig;
  wire          cascade;
  wire          trig_load_b;
  wire          load_a;
  wire          load_b;
  wire [CW-1:0] count_a;
  wire [CW-1:0] count_b;
  wire          done_a;
  wire          done_b;
  wire          active_a;
  wire          active_b;
  wire [1:0]    clr_bits;

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then the access completes

  // the access happens at the edge where waitrequest is seen low
  assign acc_go  = (avs_read_in || avs_write_in) && !wait_reg;
  assign acc_wr  = acc_go && avs_write_in && avs_byteenable_in[0];
  assign acc_idx = avs_address_in[5:2];

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      wait_reg <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, latched during the wait cycle so data stand at completion

  always @* begin
    rdata_next = 32'h0000_0000;
    case (acc_idx)
      `DPDC_IDX_CTRL: begin
        rdata_next[`DPDC_CTRL_RUN_A]    = run_a_reg;
        rdata_next[`DPDC_CTRL_CONT_A]   = cont_a_reg;
        rdata_next[`DPDC_CTRL_ACTIVE_A] = active_a;
        rdata_next[`DPDC_CTRL_RUN_B]    = run_b_reg;
        rdata_next[`DPDC_CTRL_CONT_B]   = cont_b_reg;
        rdata_next[`DPDC_CTRL_ACTIVE_B] = active_b;
      end
      `DPDC_IDX_RELOAD_A: rdata_next[CW-1:0] = reload_a_reg;
      `DPDC_IDX_RELOAD_B: rdata_next[CW-1:0] = reload_b_reg;
      `DPDC_IDX_SCALE_A:  rdata_next[PW-1:0] = scale_a_reg;
      `DPDC_IDX_SCALE_B:  rdata_next[PW-1:0] = scale_b_reg;
      // live counts only; prescaler state has no read path at all
      `DPDC_IDX_COUNT_A:  rdata_next[CW-1:0] = count_a;
      `DPDC_IDX_COUNT_B:  rdata_next[CW-1:0] = count_b;
      `DPDC_IDX_MODE:     rdata_next[6:0]    = mode_reg;
      `DPDC_IDX_STATUS:   rdata_next[1:0]    = status_reg;
      `DPDC_IDX_MASK:     rdata_next[1:0]    = mask_reg;
      default:            rdata_next         = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_in && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      run_a_reg     <= 1'b0;
      cont_a_reg    <= 1'b0;
      run_b_reg     <= 1'b0;
      cont_b_reg    <= 1'b0;
      restart_a_reg <= 1'b0;
      restart_b_reg <= 1'b0;
      reload_a_reg  <= `DPDC_RST_RELOAD;
      reload_b_reg  <= `DPDC_RST_RELOAD;
      scale_a_reg   <= `DPDC_RST_SCALE;
      scale_b_reg   <= `DPDC_RST_SCALE;
      mode_reg      <= `DPDC_RST_MODE;
      mask_reg      <= `DPDC_RST_MASK;
    end else begin
      restart_a_reg <= 1'b0;
      restart_b_reg <= 1'b0;
      if (acc_wr) begin
        case (acc_idx)
          `DPDC_IDX_CTRL: begin
            // clearing run freezes the count; setting it again resumes
            run_a_reg     <= avs_writedata_in[`DPDC_CTRL_RUN_A];
            cont_a_reg    <= avs_writedata_in[`DPDC_CTRL_CONT_A];
            restart_a_reg <= avs_writedata_in[`DPDC_CTRL_RESTART_A];
            run_b_reg     <= avs_writedata_in[`DPDC_CTRL_RUN_B];
            cont_b_reg    <= avs_writedata_in[`DPDC_CTRL_CONT_B];
            restart_b_reg <= avs_writedata_in[`DPDC_CTRL_RESTART_B];
          end
          `DPDC_IDX_RELOAD_A: reload_a_reg <= avs_writedata_in[CW-1:0];
          `DPDC_IDX_RELOAD_B: reload_b_reg <= avs_writedata_in[CW-1:0];
          `DPDC_IDX_SCALE_A:  scale_a_reg  <= avs_writedata_in[PW-1:0];
          `DPDC_IDX_SCALE_B:  scale_b_reg  <= avs_writedata_in[PW-1:0];
          `DPDC_IDX_MODE:     mode_reg     <= avs_writedata_in[6:0];
          `DPDC_IDX_MASK:     mask_reg     <= avs_writedata_in[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  assign src_mode = mode_reg[`DPDC_MODE_SRC_HI:`DPDC_MODE_SRC_LO];
  assign out_sel  = mode_reg[`DPDC_MODE_OSEL_HI:`DPDC_MODE_OSEL_LO];
  assign retrig   = mode_reg[`DPDC_MODE_RETRIG];
  assign cascade  = mode_reg[`DPDC_MODE_CASCADE];

  ////////////////////////////////////////////////////////////////////////
  // internal clock divided by four, and external pin synchroniser

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      div_reg <= {`DPDC_INT_DIV_W{1'b0}};
    end else begin
      div_reg <= div_reg + {{(`DPDC_INT_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign tick_int = (div_reg == `DPDC_INT_DIV_LAST);

  // pin_meta_reg feeds only pin_sync_reg
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= timer_in_pin_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // edge detect needs the pin high and low for a clock each; 1 MHz leaves margin
  assign ext_edge = pin_sync_reg && !pin_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // timer one input selection

  always @* begin
    tick_b_next = 1'b0;
    if (cascade) begin
      tick_b_next = done_a;
    end else begin
      case (src_mode)
        `DPDC_SRC_INTERNAL:  tick_b_next = tick_int;
        `DPDC_SRC_EXT_CLOCK: tick_b_next = ext_edge;
        `DPDC_SRC_TRIGGER:   tick_b_next = tick_int;
        `DPDC_SRC_GATE:      tick_b_next = tick_int && pin_sync_reg;
        default:             tick_b_next = 1'b0;
      endcase
    end
  end

  // a trigger edge starts a count; while active only a retriggerable mode reloads
  assign trig_load_b = (src_mode == `DPDC_SRC_TRIGGER) && ext_edge && (retrig || !active_b);
  assign load_a      = restart_a_reg;
  assign load_b      = restart_b_reg || trig_load_b;

  ////////////////////////////////////////////////////////////////////////
  // the two channels; timer zero only ever sees the internal clock

  dpdc_chan #(
    .CW (CW),
    .PW (PW)
  ) u_timer_zero (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (tick_int),
    .run_in     (run_a_reg),
    .load_in    (load_a),
    .cont_in    (cont_a_reg),
    .scale_in   (scale_a_reg),
    .reload_in  (reload_a_reg),
    .count_out  (count_a),
    .done_out   (done_a),
    .active_out (active_a)
  );

  dpdc_chan #(
    .CW (CW),
    .PW (PW)
  ) u_timer_one (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (tick_b_next),
    .run_in     (run_b_reg),
    .load_in    (load_b),
    .cont_in    (cont_b_reg),
    .scale_in   (scale_b_reg),
    .reload_in  (reload_b_reg),
    .count_out  (count_b),
    .done_out   (done_b),
    .active_out (active_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // timer output pin: each timer toggles its line at end of count

  always @* begin
    case (out_sel)
      `DPDC_OSEL_TIMER_A:   timer_out_pin_next = tog_a_reg;
      `DPDC_OSEL_TIMER_B:   timer_out_pin_next = tog_b_reg;
      `DPDC_OSEL_INT_CLOCK: timer_out_pin_next = tog_clk_reg;
      default:              timer_out_pin_next = 1'b0;
    endcase
  end

  // the internal clock can only leave as half rate, since the pin comes from a flop
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      tog_a_reg   <= 1'b0;
      tog_b_reg   <= 1'b0;
      tog_clk_reg <= 1'b0;
      timer_out_pin_reg    <= 1'b0;
      timer_out_pin_oe_reg <= 1'b0;
    end else begin
      tog_a_reg   <= tog_a_reg ^ done_a;
      tog_b_reg   <= tog_b_reg ^ done_b;
      tog_clk_reg <= ~tog_clk_reg;
      timer_out_pin_reg    <= timer_out_pin_next;
      timer_out_pin_oe_reg <= mode_reg[`DPDC_MODE_OUT_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: set on end of count, write one to clear, set wins

  assign clr_bits = (acc_wr && (acc_idx == `DPDC_IDX_STATUS)) ? avs_writedata_in[1:0] : 2'h0;

  always @* begin
    status_next    = status_reg & ~clr_bits;
    status_next[0] = status_next[0] | done_a;
    status_next[1] = status_next[1] | done_b;
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      status_reg <= 2'h0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata_out     = rdata_reg;
  assign avs_waitrequest_out  = wait_reg;
  assign port3_line6_out      = timer_out_pin_reg;
  assign port3_line6_oe_out   = timer_out_pin_oe_reg;
  assign count_done_req_a_out = status_reg[0];
  assign count_done_req_b_out = status_reg[1];
  assign irq_out              = irq_reg;

endmodule // dpdc_timer

// ===== dpdc_timer_props.sv
// checker for the timer block's bus, request and pin ports
`timescale 1ns/100ps
module dpdc_timer_props #(
  parameter CW = 8,
  parameter PW = 6
) (
  // clock and reset
  input wire        clock_in,
  input wire        rst_n_in,
  // bus
  input wire [5:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0]  avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  // pins and requests
  input wire        timer_in_pin_in,
  input wire        port3_line6_out,
  input wire        port3_line6_oe_out,
  input wire        count_done_req_a_out,
  input wire        count_done_req_b_out,
  input wire        irq_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  wire      wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire      wr_st = wr_ok && (avs_address_in[5:2] == 4'h8);
  reg [3:0] since_mode_reg;
  // oe may only move shortly after a mode write lands
  always @(posedge clock_in) begin
    if (!rst_n_in)
      since_mode_reg <= 4'hf;
    else if (wr_ok && avs_address_in[5:2] == 4'h7)
      since_mode_reg <= 4'h0;
    else if (since_mode_reg != 4'hf)
      since_mode_reg <= since_mode_reg + 4'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  a_wait_answer: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest did not drop one cycle after a request");
  a_wait_one: assert property (
    $fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  a_idle_wait: assert property (
    !avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  a_unmapped_zero: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in[5:2] >= 4'ha |-> avs_readdata_out == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_rdata_hold: assert property (
    !$past(avs_read_in) |-> $stable(avs_readdata_out))
    else $error("read data changed without a read");
  a_req_a_sticky: assert property (
    count_done_req_a_out && !wr_st && !$past(wr_st) |=> count_done_req_a_out)
    else $error("timer zero request dropped without a clear");
  a_req_b_sticky: assert property (
    count_done_req_b_out && !wr_st && !$past(wr_st) |=> count_done_req_b_out)
    else $error("timer one request dropped without a clear");
  a_irq_cause: assert property (
    $rose(irq_out) |-> ##[0:1] (count_done_req_a_out || count_done_req_b_out))
    else $error("interrupt raised with no pending request");
  a_oe_cause: assert property (
    $changed(port3_line6_oe_out) |-> since_mode_reg <= 4'h3)
    else $error("output enable moved without a mode write");
  c_req_a: cover property ($rose(count_done_req_a_out));
  c_req_b: cover property ($rose(count_done_req_b_out));
  c_irq: cover property ($rose(irq_out));
  c_oe: cover property ($rose(port3_line6_oe_out));
endmodule // dpdc_timer_props

bind dpdc_timer dpdc_timer_props #(.CW(CW), .PW(PW)) u_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .timer_in_pin_in(timer_in_pin_in),
  .port3_line6_out(port3_line6_out), .port3_line6_oe_out(port3_line6_oe_out),
  .count_done_req_a_out(count_done_req_a_out), .count_done_req_b_out(count_done_req_b_out),
  .irq_out(irq_out));

// ===== dpdc_pin_src.sv
// external clock, trigger and gate source for the timer input pin
`timescale 1ns/100ps
module dpdc_pin_src (
  // control
  input  wire       clock_in,
  input  wire       start_in,
  input  wire [3:0] count_in,
  input  wire       hold_in,
  // pin and state
  output reg        pin_out,
  output wire       busy_out
);
  reg [3:0] left_reg;
  reg [3:0] ph_reg;
  assign busy_out = (left_reg != 4'h0);
  initial begin
    left_reg = 4'h0;
    ph_reg = 4'h0;
    pin_out = 1'b0;
  end
  // ten cycles per pulse keeps the pin at 1 MHz at most
  always @(posedge clock_in) begin
    if (start_in && !busy_out) begin
      left_reg <= count_in;
      ph_reg <= 4'h0;
    end else if (busy_out) begin
      ph_reg <= (ph_reg == 4'h9) ? 4'h0 : ph_reg + 4'h1;
      if (ph_reg == 4'h9)
        left_reg <= left_reg - 4'h1;
    end
    // once the pulses are done the pin rests at the gate level; within a burst it is low between pulses
    pin_out <= busy_out ? (ph_reg < 4'h5) : hold_in;
  end
endmodule // dpdc_pin_src

// ===== dpdc_timer_tb.sv
// self-checking bench for the dual prescaled down counter
`timescale 1ns/100ps
module dpdc_timer_tb;
  reg         clock_in;
  reg         rst_n_in;
  reg  [5:0]  avs_address_in;
  reg         avs_read_in;
  reg         avs_write_in;
  reg  [31:0] avs_writedata_in;
  reg  [3:0]  avs_byteenable_in;
  wire [31:0] avs_readdata_out;
  wire        avs_waitrequest_out;
  wire        pin;
  wire        p36;
  wire        p36_oe;
  wire        req_a;
  wire        req_b;
  wire        irq_out;
  reg         src_start;
  reg  [3:0]  src_count;
  reg         src_hold;
  wire        src_busy;
  integer     n_errors;
  integer     checks_done;
  integer     cycles;
  integer     seed;
  integer     ch;
  integer     n;
  integer     e;
  reg  [31:0] rd;
  reg  [31:0] c1;
  reg  [31:0] c2;

  dpdc_timer dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .timer_in_pin_in(pin), .port3_line6_out(p36),
    .port3_line6_oe_out(p36_oe), .count_done_req_a_out(req_a), .count_done_req_b_out(req_b),
    .irq_out(irq_out));
  dpdc_pin_src u_src (.clock_in(clock_in), .start_in(src_start), .count_in(src_count),
    .hold_in(src_hold), .pin_out(pin), .busy_out(src_busy));

  //////////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer k);
    repeat (k) @(posedge clock_in);
  endtask
  // one access, held until waitrequest is seen low at a rising edge
  task bus(input wr, input [3:0] idx, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clock_in);
      avs_address_in <= {idx, 2'b00};
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      @(posedge clock_in);
      while (avs_waitrequest_out !== 1'b0 && t < 50) begin
        @(posedge clock_in);
        t = t + 1;
      end
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      check(t < 50, 1);
    end
  endtask
  task wait_for(input b, input integer lim);
    begin
      n = 0;
      while ((b ? req_b : req_a) !== 1'b1 && n < lim) begin
        @(posedge clock_in);
        n = n + 1;
      end
    end
  endtask
  task pulses(input [3:0] k);
    begin
      src_count <= k;
      src_start <= 1'b1;
      @(posedge clock_in);
      src_start <= 1'b0;
    end
  endtask
  task toggles(input integer k);
    begin
      e = 0;
      c1 = p36;
      repeat (k) begin
        @(posedge clock_in);
        if (p36 !== c1[0])
          e = e + 1;
        c1 = p36;
      end
    end
  endtask
  function integer per(input integer s, input integer r);
    per = 4 * (s == 0 ? 64 : s) * (r == 0 ? 256 : r);
  endfunction

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end

  initial begin
    seed = 32'h6c0101e6;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    rst_n_in = 1'b0;
    {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = 0;
    avs_byteenable_in = 4'hf;
    {src_start, src_count, src_hold} = 0;
    idle(4);
    rst_n_in <= 1'b1;
    check({p36_oe, irq_out, req_a, req_b, avs_waitrequest_out}, 5'h01);
    for (ch = 0; ch < 11; ch = ch + 1) begin
      bus(0, ch[3:0], 0);
      check(rd, 0);
    end
    // a write without byte lane zero must leave the register alone
    avs_byteenable_in <= 4'he;
    bus(1, 1, 32'h55);
    avs_byteenable_in <= 4'hf;
    bus(0, 1, 0);
    check(rd, 0);
    // single pass on each timer, random reload and scale
    for (ch = 0; ch < 2; ch = ch + 1) begin
      c1 = 2 + {$random(seed)} % 4;
      c2 = 1 + {$random(seed)} % 3;
      bus(1, 1 + ch, c1);
      bus(1, 3 + ch, c2);
      bus(1, 9, 3);
      bus(1, 0, 32'h3 << (4 * ch));
      wait_for(ch[0], 200);
      e = per(c2, c1);
      check(n >= e && n <= e + 3, 1);
      check({req_b, req_a, irq_out}, {ch == 1, ch == 0, 1'b1});
      idle(e);
      bus(0, 5 + ch, 0);
      check(rd, 0);
      bus(0, 0, 0);
      check(rd, 32'h1 << (4 * ch));
      bus(1, 9, 0);
      idle(2);
      check(irq_out, 0);
      bus(1, 9, 3);
      idle(2);
      check(irq_out, 1);
      bus(1, 8, 3);
      idle(2);
      check({req_b, req_a, irq_out}, 0);
      bus(1, 0, 0);
    end
    // stop, resume and restart
    bus(1, 1, 32'hc8);
    bus(1, 3, 1);
    bus(1, 0, 3);
    idle(40);
    bus(1, 0, 0);
    bus(0, 5, 0);
    c2 = rd;
    idle(40);
    bus(0, 5, 0);
    check(rd, c2);
    check(c2 < 200 && c2 > 180, 1);
    bus(1, 0, 1);
    idle(40);
    bus(0, 5, 0);
    check(rd < c2 && rd > c2 - 16, 1);
    bus(1, 0, 3);
    bus(0, 5, 0);
    check(rd >= 32'hc6 && rd <= 32'hc8, 1);
    // continuous mode seen on the output pin, then the other selections
    bus(1, 7, 32'h40);
    bus(1, 1, 2);
    bus(1, 0, 7);
    idle(4);
    toggles(80);
    check(e >= 9 && e <= 11, 1);
    check(p36_oe, 1);
    bus(1, 7, 32'h60);
    idle(4);
    toggles(8);
    check(e, 8);
    bus(1, 7, 32'h50);
    idle(4);
    toggles(20);
    check(e, 0);
    bus(1, 7, 0);
    idle(4);
    check(p36_oe, 0);
    bus(1, 0, 0);
    bus(1, 8, 3);
    // external clock on timer one
    bus(1, 7, 1);
    bus(1, 2, 3);
    bus(1, 4, 1);
    bus(1, 0, 32'h30);
    pulses(2);
    idle(30);
    check(req_b, 0);
    pulses(1);
    wait_for(1, 40);
    check(req_b, 1);
    bus(1, 8, 3);
    // trigger, one-shot then retriggerable
    for (ch = 0; ch < 2; ch = ch + 1) begin
      bus(1, 7, ch ? 6 : 2);
      bus(1, 2, 4);
      bus(1, 0, 32'h10);
      pulses(2);
      wait_for(1, 80);
      check(n > 23 && n < 80, ch);
      idle(20);
      bus(1, 8, 3);
    end
    // gate holds the count while the pin is low
    bus(1, 7, 3);
    bus(1, 2, 32'hc8);
    bus(1, 0, 32'h30);
    idle(40);
    bus(0, 6, 0);
    c2 = rd;
    check(c2, 32'hc8);
    src_hold <= 1'b1;
    idle(40);
    bus(0, 6, 0);
    src_hold <= 1'b0;
    check(rd < c2 && rd > c2 - 16, 1);
    // cascade: timer one counts timer zero ends
    bus(1, 7, 8);
    bus(1, 1, 3);
    bus(1, 2, 2);
    bus(1, 0, 32'h37);
    wait_for(1, 60);
    check(n >= 18 && n <= 30, 1);
    bus(1, 0, 0);
    complete_run;
  end
endmodule // dpdc_timer_tb
